/* File: shared/bcc_pkg.sv */
/*
  Constants shared by the flash CRC command handler: framing bytes,
  command and response codes, status codes, CRC settings, area table.
  Assumes a byte-wide packet stream and a 32-bit word flash read port.
*/
package bcc_pkg;
  // Framing
  localparam logic [7:0] CMD_HDR = 8'h01;
  localparam logic [7:0] RSP_HDR = 8'h81;
  localparam logic [7:0] TRAILER = 8'h03;
  localparam logic [7:0] CRC_CODE = 8'h18;
  localparam logic [7:0] CRC_ERR_CODE = 8'h98;
  localparam logic [7:0] CANCEL_CODE = 8'hFF;
  localparam logic [7:0] CANCEL_SUM = 8'h00;
  localparam logic [15:0] CRC_CMD_LEN = 16'h0009;
  localparam logic [15:0] CANCEL_LEN = 16'h0001;
  localparam logic [7:0] OK_LEN_LOW = 8'h05;
  localparam logic [7:0] ERR_LEN_LOW = 8'h02;
  localparam logic [7:0] LEN_HIGH = 8'h00;
  localparam int PARAM_BYTES = 9;
  localparam int RESP_BYTES = 10;
  localparam int ERR_BYTES = 7;
  // Status code values (arbitrary encodings)
  localparam logic [7:0] STS_PACKET = 8'hC1;
  localparam logic [7:0] STS_CHECKSUM = 8'hC2;
  localparam logic [7:0] STS_FLOW = 8'hC3;
  localparam logic [7:0] STS_ADDRESS = 8'hD0;
  localparam logic [7:0] STS_WINDOW = STS_ADDRESS;
  // CRC
  localparam logic [31:0] CRC_PRESET = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] WORD_STEP = 32'h00000004;
  // Area kinds
  localparam logic [7:0] KIND_USER = 8'h00;
  localparam logic [7:0] KIND_DATA = 8'h01;
  localparam logic [7:0] KIND_CONFIG = 8'h02;
  // Area table
  localparam int NUM_AREAS = 3;
  localparam int AREA_IDX_W = 2;
  localparam logic [31:0] AREA_START [NUM_AREAS] =
    '{32'h00000000, 32'h40100000, 32'h01010008};
  localparam logic [31:0] AREA_END [NUM_AREAS] =
    '{32'h0001FFFF, 32'h40100FFF, 32'h01010033};
  localparam logic [7:0] AREA_KIND [NUM_AREAS] =
    '{KIND_USER, KIND_DATA, KIND_CONFIG};
  localparam logic [31:0] AREA_ERASE_UNIT [NUM_AREAS] =
    '{32'h00000800, 32'h00000400, 32'h00000000};
  localparam logic [31:0] AREA_WRITE_UNIT [NUM_AREAS] =
    '{32'h00000008, 32'h00000001, 32'h00000004};
endpackage : bcc_pkg

/* File: design/bcc_crc32_word.sv */
/*
  One 32-bit word step of the CRC: 32 data bits, MSB first, left shift.
  Assumes the caller holds the running CRC register.
*/
`timescale 1ns/10ps
module bcc_crc32_word #(
  parameter logic [31:0] POLY = bcc_pkg::CRC_POLY
) (
  input wire logic [31:0] crc_in,
  input wire logic [31:0] data_in,
  output logic [31:0] crc_out
);
  always_comb begin
    logic [31:0] c;
    c = crc_in;
    for (int i = 31; i >= 0; i--) begin
      if (c[31] ^ data_in[i]) begin
        c = {c[30:0], 1'b0} ^ POLY;
      end else begin
        c = {c[30:0], 1'b0};
      end
    end
    crc_out = c;
  end
endmodule : bcc_crc32_word

/* File: design/bcc_crc_cmd.sv */
/*
  Flash CRC command handler: receives framed packets, checks the CRC
  command, reads flash word by word, answers with a CRC or error packet,
  and honours host cancel packets.
  Assumes a byte stream in, a byte stream out with ready, and a flash
  read port that answers each held request with a one-cycle ack.
*/
`timescale 1ns/10ps
module bcc_crc_cmd (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  output logic rx_ready_out,
  input wire logic auth_phase_in,
  input wire logic [31:0] window_start_in,
  input wire logic [31:0] window_end_in,
  output logic flash_rd_out,
  output logic [31:0] flash_addr_out,
  input wire logic flash_ack_in,
  input wire logic [31:0] flash_data_in,
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  input wire logic tx_ready_in,
  output logic cancel_out,
  output logic erase_ok_out,
  output logic write_ok_out
);
  typedef enum logic [3:0] {
    ST_HDR, ST_LNH, ST_LNL, ST_BODY, ST_SUM, ST_ETX,
    ST_CHECK, ST_READ, ST_SEND
  } bcc_state_t;

  localparam int AW = bcc_pkg::AREA_IDX_W;

  bcc_state_t state_q;
  logic [7:0] hdr_q;
  logic [15:0] len_q;
  logic [15:0] cnt_q;
  logic [7:0] par_q [bcc_pkg::PARAM_BYTES];
  logic [7:0] sum_q;
  logic [7:0] etx_q;
  logic [31:0] addr_q;
  logic [31:0] crc_q;
  logic [31:0] crc_next;
  logic [7:0] resp_q [bcc_pkg::RESP_BYTES];
  logic [3:0] left_q;
  logic rx_take;
  logic [31:0] sa;
  logic [31:0] ea;
  logic [AW:0] sa_area;
  logic [AW:0] ea_area;
  logic [7:0] sa_kind;
  logic [7:0] ea_kind;
  logic fail;
  logic [7:0] sts;
  logic cancel_ok;

  // Returns {hit, index} of the area holding an address
  function automatic logic [AW:0] area_of(input logic [31:0] a);
    logic [AW:0] r;
    r = '0;
    for (int i = bcc_pkg::NUM_AREAS - 1; i >= 0; i--) begin
      if (a >= bcc_pkg::AREA_START[i] && a <= bcc_pkg::AREA_END[i]) begin
        r = {1'b1, AW'(i)};
      end
    end
    return r;
  endfunction : area_of

  // Two's complement of a byte total, for the outgoing sum byte
  function automatic logic [7:0] neg8(input logic [7:0] v);
    return 8'h00 - v;
  endfunction : neg8

  assign rx_ready_out = (state_q <= bcc_state_t'(ST_ETX));
  assign rx_take = rx_valid_in && rx_ready_out;
  assign flash_rd_out = (state_q == ST_READ);
  assign flash_addr_out = addr_q;
  assign tx_valid_out = (state_q == ST_SEND);
  assign tx_data_out = resp_q[0];

  bcc_crc32_word u_crc (
    .crc_in(crc_q),
    .data_in(flash_data_in),
    .crc_out(crc_next)
  );

  assign sa = {par_q[1], par_q[2], par_q[3], par_q[4]};
  assign ea = {par_q[5], par_q[6], par_q[7], par_q[8]};
  assign sa_area = area_of(sa);
  assign ea_area = area_of(ea);
  assign sa_kind = bcc_pkg::AREA_KIND[sa_area[AW-1:0]];
  assign ea_kind = bcc_pkg::AREA_KIND[ea_area[AW-1:0]];

  // Ordered checks, first match wins
  always_comb begin
    fail = 1'b1;
    sts = bcc_pkg::STS_PACKET;
    if (etx_q != bcc_pkg::TRAILER) begin
      sts = bcc_pkg::STS_PACKET;
    end else if (sum_q != 8'h00) begin
      sts = bcc_pkg::STS_CHECKSUM;
    end else if (len_q == 16'h0000) begin
      sts = bcc_pkg::STS_PACKET;
    end else if (len_q != bcc_pkg::CRC_CMD_LEN) begin
      sts = bcc_pkg::STS_PACKET;
    end else if (auth_phase_in) begin
      sts = bcc_pkg::STS_FLOW;
    end else if (sa > ea) begin
      sts = bcc_pkg::STS_ADDRESS;
    end else if (!sa_area[AW] || !ea_area[AW]) begin
      sts = bcc_pkg::STS_ADDRESS;
    end else if (sa_kind != ea_kind) begin
      sts = bcc_pkg::STS_ADDRESS;
    end else if (sa[1:0] != 2'b00 || ea[1:0] != 2'b00) begin
      sts = bcc_pkg::STS_ADDRESS;
    end else if (sa_kind == bcc_pkg::KIND_USER &&
                 (sa < window_start_in || ea > window_end_in)) begin
      sts = bcc_pkg::STS_WINDOW;
    end else begin
      fail = 1'b0;
    end
  end

  assign cancel_ok = hdr_q == bcc_pkg::RSP_HDR &&
                     etx_q == bcc_pkg::TRAILER &&
                     len_q == bcc_pkg::CANCEL_LEN &&
                     par_q[0] == bcc_pkg::CANCEL_CODE &&
                     sum_q == bcc_pkg::CANCEL_SUM;

  // Packet receive, check, read and send sequencing
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state_q <= ST_HDR;
    end else begin
      case (state_q)
        ST_HDR: begin
          if (rx_take && (rx_data_in == bcc_pkg::CMD_HDR ||
                          rx_data_in == bcc_pkg::RSP_HDR)) begin
            state_q <= ST_LNH;
          end
        end
        ST_LNH: begin
          if (rx_take) begin
            state_q <= ST_LNL;
          end
        end
        ST_LNL: begin
          if (rx_take) begin
            state_q <= ({len_q[7:0], rx_data_in} == 16'h0000) ?
                       ST_SUM : ST_BODY;
          end
        end
        ST_BODY: begin
          if (rx_take && cnt_q == len_q - 16'h0001) begin
            state_q <= ST_SUM;
          end
        end
        ST_SUM: begin
          if (rx_take) begin
            state_q <= ST_ETX;
          end
        end
        ST_ETX: begin
          if (rx_take) begin
            state_q <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (hdr_q != bcc_pkg::CMD_HDR) begin
            state_q <= ST_HDR;
          end else if (par_q[0] != bcc_pkg::CRC_CODE &&
                       etx_q == bcc_pkg::TRAILER) begin
            state_q <= ST_HDR;
          end else if (fail) begin
            state_q <= ST_SEND;
          end else begin
            state_q <= ST_READ;
          end
        end
        ST_READ: begin
          if (flash_ack_in && addr_q == ea) begin
            state_q <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (tx_ready_in && left_q == 4'd1) begin
            state_q <= ST_HDR;
          end
        end
        default: begin
          state_q <= ST_HDR;
        end
      endcase
    end
  end

  // Captured packet fields
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      hdr_q <= 8'h00;
      len_q <= 16'h0000;
      cnt_q <= 16'h0000;
      sum_q <= 8'h00;
      etx_q <= 8'h00;
      for (int i = 0; i < bcc_pkg::PARAM_BYTES; i++) begin
        par_q[i] <= 8'h00;
      end
    end else if (rx_take) begin
      case (state_q)
        ST_HDR: begin
          hdr_q <= rx_data_in;
          sum_q <= 8'h00;
          cnt_q <= 16'h0000;
        end
        ST_LNH: begin
          len_q <= {8'h00, rx_data_in};
          sum_q <= sum_q + rx_data_in;
        end
        ST_LNL: begin
          len_q <= {len_q[7:0], rx_data_in};
          sum_q <= sum_q + rx_data_in;
        end
        ST_BODY: begin
          if (cnt_q < 16'(bcc_pkg::PARAM_BYTES)) begin
            par_q[cnt_q[3:0]] <= rx_data_in;
          end
          cnt_q <= cnt_q + 16'h0001;
          sum_q <= sum_q + rx_data_in;
        end
        ST_SUM: begin
          sum_q <= sum_q + rx_data_in;
        end
        ST_ETX: begin
          etx_q <= rx_data_in;
        end
        default: begin
          etx_q <= etx_q;
        end
      endcase
    end
  end

  // Flash walk and CRC accumulation
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      addr_q <= 32'h00000000;
      crc_q <= bcc_pkg::CRC_PRESET;
    end else if (state_q == ST_CHECK) begin
      addr_q <= sa;
      crc_q <= bcc_pkg::CRC_PRESET;
    end else if (state_q == ST_READ && flash_ack_in) begin
      crc_q <= crc_next;
      addr_q <= addr_q + bcc_pkg::WORD_STEP;
    end
  end

  // Reply packet build and byte shift-out
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      left_q <= 4'd0;
      for (int i = 0; i < bcc_pkg::RESP_BYTES; i++) begin
        resp_q[i] <= 8'h00;
      end
    end else if (state_q == ST_CHECK && fail) begin
      resp_q[0] <= bcc_pkg::RSP_HDR;
      resp_q[1] <= bcc_pkg::LEN_HIGH;
      resp_q[2] <= bcc_pkg::ERR_LEN_LOW;
      resp_q[3] <= bcc_pkg::CRC_ERR_CODE;
      resp_q[4] <= sts;
      resp_q[5] <= neg8(bcc_pkg::ERR_LEN_LOW + bcc_pkg::CRC_ERR_CODE + sts);
      resp_q[6] <= bcc_pkg::TRAILER;
      left_q <= 4'(bcc_pkg::ERR_BYTES);
    end else if (state_q == ST_READ && flash_ack_in && addr_q == ea) begin
      resp_q[0] <= bcc_pkg::RSP_HDR;
      resp_q[1] <= bcc_pkg::LEN_HIGH;
      resp_q[2] <= bcc_pkg::OK_LEN_LOW;
      resp_q[3] <= bcc_pkg::CRC_CODE;
      resp_q[4] <= crc_next[31:24];
      resp_q[5] <= crc_next[23:16];
      resp_q[6] <= crc_next[15:8];
      resp_q[7] <= crc_next[7:0];
      resp_q[8] <= neg8(bcc_pkg::OK_LEN_LOW + bcc_pkg::CRC_CODE +
                        crc_next[31:24] + crc_next[23:16] +
                        crc_next[15:8] + crc_next[7:0]);
      resp_q[9] <= bcc_pkg::TRAILER;
      left_q <= 4'(bcc_pkg::RESP_BYTES);
    end else if (state_q == ST_SEND && tx_ready_in) begin
      for (int i = 0; i < bcc_pkg::RESP_BYTES - 1; i++) begin
        resp_q[i] <= resp_q[i + 1];
      end
      left_q <= left_q - 4'd1;
    end
  end

  // Cancel pulse and per-area operation support of the start address
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      cancel_out <= 1'b0;
      erase_ok_out <= 1'b0;
      write_ok_out <= 1'b0;
    end else begin
      cancel_out <= (state_q == ST_CHECK) && cancel_ok;
      if (state_q == ST_CHECK && sa_area[AW]) begin
        erase_ok_out <=
          bcc_pkg::AREA_ERASE_UNIT[sa_area[AW-1:0]] != 32'h00000000;
        write_ok_out <=
          bcc_pkg::AREA_WRITE_UNIT[sa_area[AW-1:0]] != 32'h00000000;
      end
    end
  end
endmodule : bcc_crc_cmd

/* File: tb/bcc_crc_cmd_assertions.sv */
/* Port checker for the flash CRC command handler.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/10ps
module bcc_crc_cmd_assertions (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic rx_ready_out,
  input wire logic flash_rd_out,
  input wire logic [31:0] flash_addr_out,
  input wire logic flash_ack_in,
  input wire logic tx_valid_out,
  input wire logic [7:0] tx_data_out,
  input wire logic tx_ready_in,
  input wire logic cancel_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_last_word;
    flash_rd_out && flash_ack_in ##1 !flash_rd_out;
  endsequence
  sequence s_reply_begin;
    $rose(tx_valid_out) && tx_data_out == 8'h81;
  endsequence
  a_reset_idle: assert property (disable iff (1'b0)
    !rst_b_in |=> !tx_valid_out && !flash_rd_out && rx_ready_out)
    else $error("not idle after reset");
  a_word_align: assert property (flash_rd_out |->
    flash_addr_out[1:0] == 2'h0) else $error("read not aligned");
  a_read_hold: assert property (flash_rd_out && !flash_ack_in |=>
    flash_rd_out && $stable(flash_addr_out)) else $error("read dropped");
  a_addr_step: assert property (flash_rd_out && flash_ack_in |=>
    (flash_rd_out && flash_addr_out == $past(flash_addr_out) + 32'h4)
    || (!flash_rd_out && tx_valid_out)) else $error("bad read step");
  a_crc_reply: assert property (s_last_word |-> s_reply_begin)
    else $error("no reply after last word");
  a_tx_hold: assert property (tx_valid_out && !tx_ready_in |=>
    tx_valid_out && $stable(tx_data_out)) else $error("reply byte lost");
  a_len_high: assert property ($rose(tx_valid_out) && tx_ready_in |=>
    tx_data_out == 8'h00) else $error("bad length high");
  a_busy_rx: assert property (tx_valid_out || flash_rd_out |->
    !rx_ready_out) else $error("rx open while busy");
  a_cancel_quiet: assert property (cancel_out |-> !tx_valid_out
    ##1 (!cancel_out && !tx_valid_out)) else $error("bad cancel");
endmodule : bcc_crc_cmd_assertions

bind bcc_crc_cmd bcc_crc_cmd_assertions u_chk (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .rx_ready_out(rx_ready_out),
  .flash_rd_out(flash_rd_out), .flash_addr_out(flash_addr_out),
  .flash_ack_in(flash_ack_in), .tx_valid_out(tx_valid_out),
  .tx_data_out(tx_data_out), .tx_ready_in(tx_ready_in),
  .cancel_out(cancel_out)
);

/* File: tb/bcc_flash_model.sv */
/* Flash read model: word data derived from the address.
   Assumes a read held until a one-cycle ack. */
`timescale 1ns/10ps
module bcc_flash_model (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic rd_in,
  input wire logic [31:0] addr_in,
  output logic ack_out,
  output logic [31:0] data_out
);
  logic [1:0] wait_q;
  logic go;
  assign go = rst_b_in && rd_in && !ack_out && wait_q == 2'h0;
  // Ack after 0 to 3 idle cycles
  always_ff @(posedge clk_in) begin
    if (!rst_b_in || ack_out || !rd_in) begin
      ack_out <= 1'b0;
      wait_q <= 2'($urandom_range(0, 3));
    end else if (go) begin
      ack_out <= 1'b1;
    end else begin
      wait_q <= wait_q - 2'h1;
    end
  end
  // Data toggles outside the ack cycle
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) data_out <= 32'h0;
    else if (go) data_out <= addr_in ^ 32'hA5C31E0F;
    else data_out <= ~data_out;
  end
endmodule : bcc_flash_model

/* File: tb/tb_top.sv */
/* Self-checking bench for the flash CRC command handler.
   Assumes the checker is bound and the flash model answers reads. */
`timescale 1ns/10ps
module tb_top;
  localparam logic [31:0] WIN = 32'h0001FFFF;
  logic clk_in, rst_b_in, rx_valid, rx_ready, auth, rd, ack;
  logic tx_valid, tx_ready, cancel, erase_ok, write_ok;
  logic [7:0] rx_data, tx_data;
  logic [31:0] w_start, w_end, addr, fdata, rs;
  logic [7:0] exp_q[$];
  int n_fail = 0;
  int checked = 0;
  int n_cancel = 0;
  int n_bytes = 0;
  int n_base = 0;
  bcc_crc_cmd u_dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .rx_valid_in(rx_valid),
    .rx_data_in(rx_data), .rx_ready_out(rx_ready), .auth_phase_in(auth),
    .window_start_in(w_start), .window_end_in(w_end), .flash_rd_out(rd),
    .flash_addr_out(addr), .flash_ack_in(ack), .flash_data_in(fdata),
    .tx_valid_out(tx_valid), .tx_data_out(tx_data), .tx_ready_in(tx_ready),
    .cancel_out(cancel), .erase_ok_out(erase_ok), .write_ok_out(write_ok)
  );
  bcc_flash_model u_flash (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .rd_in(rd), .addr_in(addr), .ack_out(ack), .data_out(fdata));
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  // Random reply stall; compares each byte the next edge will take
  always @(negedge clk_in) begin
    tx_ready = ($urandom_range(0, 3) != 0);
    if (tx_valid === 1'b1 && tx_ready) begin
      n_bytes++;
      if (exp_q.size() == 0) chk("extra byte", 32'h1, 32'h0);
      else chk("reply", 32'(tx_data), 32'(exp_q.pop_front()));
    end
    if (cancel === 1'b1) n_cancel++;
  end
  task automatic exp_pkt(input logic [7:0] body[$]);
    logic [7:0] sm;
    sm = 8'h0;
    exp_q.push_back(8'h81);
    foreach (body[i]) begin
      exp_q.push_back(body[i]);
      sm -= body[i];
    end
    exp_q.push_back(sm);
    exp_q.push_back(8'h03);
  endtask : exp_pkt
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      @(negedge clk_in);
      while (rx_ready !== 1'b1) @(negedge clk_in);
      rx_valid = 1'b1;
      rx_data = b[i];
    end
    @(negedge clk_in);
    rx_valid = 1'b0;
  endtask : send
  task automatic settle;
    for (int i = 0; i < 3000; i++) begin
      @(negedge clk_in);
      if (rx_ready === 1'b1 && tx_valid !== 1'b1 && exp_q.size() == 0) break;
    end
    repeat (2) @(negedge clk_in);
  endtask : settle
  task automatic tst(input logic [31:0] s, e, we, input logic [7:0] ll,
                     sx, tr, sts, input logic au);
    logic [7:0] b[$];
    logic [7:0] sm;
    logic [31:0] c, x;
    auth = au;
    w_end = we;
    if (sts != 8'h0) exp_pkt('{8'h00, 8'h02, 8'h98, sts});
    else begin
      c = bcc_pkg::CRC_PRESET;
      for (logic [31:0] a = s; a <= e; a += 32'h4) begin
        x = a ^ 32'hA5C31E0F;
        for (int j = 31; j >= 0; j--)
          c = {c[30:0], 1'b0} ^ ((c[31] ^ x[j]) ? bcc_pkg::CRC_POLY : 32'h0);
      end
      exp_pkt('{8'h00, 8'h05, 8'h18, c[31:24], c[23:16], c[15:8], c[7:0]});
    end
    b = '{8'h01, 8'h00, ll, 8'h18, s[31:24], s[23:16], s[15:8], s[7:0],
          e[31:24], e[23:16], e[15:8], e[7:0]};
    if (ll == 8'h0A) b.push_back(8'h00);
    sm = sx;
    for (int i = 1; i < b.size(); i++) sm -= b[i];
    b.push_back(sm);
    b.push_back(tr);
    send(b);
    settle;
    chk("left", 32'(exp_q.size()), 32'h0);
    $display("test %h to %h done", s, e);
  endtask : tst
  initial begin
    rst_b_in = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h0;
    auth = 1'b0;
    w_start = 32'h0;
    w_end = WIN;
    void'($urandom(9));
    repeat (3) @(negedge clk_in);
    rst_b_in = 1'b1;
    tst(32'h0, 32'hC, WIN, 8'h09, 8'h0, 8'h03, 8'h0, 1'b0);
    chk("ok user", {erase_ok, write_ok}, 32'h3);
    // Model data is defined everywhere, unlike erased data-area cells
    tst(32'h40100000, 32'h40100000, WIN, 8'h09, 8'h0, 8'h03, 8'h0,
        1'b0);
    tst(32'h01010008, 32'h01010010, WIN, 8'h09, 8'h0, 8'h03, 8'h0, 1'b0);
    chk("ok cfg", {erase_ok, write_ok}, 32'h1);
    tst(32'h8, 32'h4, WIN, 8'h09, 8'h0, 8'h03, 8'hD0, 1'b0);
    tst(32'h20000, 32'h20004, WIN, 8'h09, 8'h0, 8'h03, 8'hD0, 1'b0);
    tst(32'h0, 32'h40100000, WIN, 8'h09, 8'h0, 8'h03, 8'hD0, 1'b0);
    tst(32'h2, 32'h8, WIN, 8'h09, 8'h0, 8'h03, 8'hD0, 1'b0);
    tst(32'h0, 32'h100, 32'hFF, 8'h09, 8'h0, 8'h03, 8'hD0, 1'b0);
    w_start = 32'h100;
    tst(32'hFC, 32'h104, WIN, 8'h09, 8'h0, 8'h03, 8'hD0, 1'b0);
    tst(32'h100, 32'h104, WIN, 8'h09, 8'h0, 8'h03, 8'h0, 1'b0);
    w_start = 32'h0;
    tst(32'h8, 32'h4, WIN, 8'h09, 8'h0, 8'h03, 8'hC3, 1'b1);
    tst(32'h8, 32'h4, WIN, 8'h09, 8'h1, 8'h03, 8'hC2, 1'b1);
    tst(32'h8, 32'h4, WIN, 8'h0A, 8'h0, 8'h03, 8'hC1, 1'b1);
    tst(32'h8, 32'h4, WIN, 8'h09, 8'h1, 8'h00, 8'hC1, 1'b1);
    n_base = n_bytes;
    send('{8'h81, 8'h00, 8'h01, 8'hFF, 8'h00, 8'h03});
    settle;
    chk("cancels", n_cancel, 32'h1);
    chk("cancel reply", n_bytes - n_base, 32'h0);
    $display("test cancel done");
    // Stray byte in idle is dropped; a good packet of another code is ignored
    send('{8'h55, 8'h01, 8'h00, 8'h01, 8'h3C, 8'hC3, 8'h03});
    settle;
    chk("ignored reply", n_bytes - n_base, 32'h0);
    $display("test other code done");
    rs = $urandom_range(0, 32'h1FF00) & 32'hFFFFFFFC;
    tst(rs, rs + 4 * $urandom_range(0, 6), WIN, 8'h09, 8'h0, 8'h03, 8'h0,
        1'b0);
    report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    n_fail++;
    report_and_stop;
  end
endmodule : tb_top
